// File: common/touch_consts.svh
`ifndef TOUCH_CONSTS_SVH
`define TOUCH_CONSTS_SVH

// Channel count
`define TB_CHANNELS        4

// Strap classes as reported by the strap measurement
`define TB_STRAP_GND       2'h0
`define TB_STRAP_R1K5      2'h1
`define TB_STRAP_R5K1      2'h2
`define TB_STRAP_VDD       2'h3

// Reset values
`define TB_OUT_RST         4'h0
`define TB_STRAP_RST       2'h0

// Timing
`define TB_CLK_KHZ         50000
`define TB_BLINK_HALF_MS   250
`define TB_BLINK_HALF_CYC  ((`TB_BLINK_HALF_MS) * (`TB_CLK_KHZ))
`define TB_BLINK_PAIRS     3

`endif

// File: common/touch_pkg.sv
package touch_pkg;

    typedef enum logic [1:0] {
        ST_REQ,
        ST_WAIT,
        ST_BLINK,
        ST_RUN
    } tune_state_e;

    typedef struct packed {
        logic toggle;
        logic suppress;
    } feature_s;

endpackage : touch_pkg

// File: common/tune_if.sv
`timescale 1ns/1ns

interface tune_if #(
    parameter int N = 4
);
    logic         ready;
    logic         blink;
    logic [N-1:0] bad_mask;

    modport src  (output ready, output blink, output bad_mask);
    modport sink (input  ready, input  blink, input  bad_mask);
endinterface : tune_if

// File: core/touch_button_output_logic.sv
`timescale 1ns/1ns
`include "touch_consts.svh"

// How it works
// - Auto-tuning runs by itself after power-up and never again while running.
// - Every external reset also restarts auto-tuning of all sensors.
// - Strap is captured only after reset; outside must reset after changing it.
// - Toggle off: output follows its sensor's touch directly.
// - Toggle on: each new touch inverts the output, held through release.
// - Suppression on: at most one button reported at a time.
// - Suppression on: the first touched sensor wins.
// - Suppression on: the active sensor keeps ownership while still touched.
// - Suppression on: simultaneous touches pick lowest index first.
// - Suppression on: releasing the owner hands over to a still-touched sensor.
// - Suppression off: every sensor drives its own output freely.
// - Strap ground or floating selects nothing; 1.5 kilohm selects toggle.
// - Strap 5.1 kilohm selects suppression; supply selects both.
// - Over-range sensors blink at start-up and are ignored afterwards.
// - External reset is active high; outside asserts it to reset.
// - Each output depends only on the decision for its own channel.
module touch_button_output_logic #(
    parameter int unsigned BLINK_HALF_CYC = `TB_BLINK_HALF_CYC,
    parameter int unsigned BLINK_PAIRS    = `TB_BLINK_PAIRS
) (
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    // Feature strap class, asynchronous pin
    input  wire logic [1:0]              feature_strap_pin,
    // Sensing front end
    input  wire logic                    sense_in_0,
    input  wire logic                    sense_in_1,
    input  wire logic                    sense_in_2,
    input  wire logic                    sense_in_3,
    input  wire logic                    scan_valid,
    input  wire logic                    tune_done,
    input  wire logic [`TB_CHANNELS-1:0] cap_over,
    output logic                         tune_start,
    // Button outputs
    output logic                         button_out_0,
    output logic                         button_out_1,
    output logic                         button_out_2,
    output logic                         button_out_3,
    // Status
    output logic                         tuning_active,
    output logic                         toggle_mode,
    output logic                         single_active_suppression
);

    localparam int N = `TB_CHANNELS;

    tune_if #(.N(N)) tif ();

    logic [1:0]        strap_s1_ff, nxt_strap_s1;
    logic [1:0]        strap_s2_ff, nxt_strap_s2;
    logic              toggle_en_ff, nxt_toggle_en;
    logic              fss_en_ff, nxt_fss_en;
    logic              run_ff, nxt_run;
    logic              capture;
    touch_pkg::feature_s strap_feat;

    logic [N-1:0]      sense;
    logic [N-1:0]      valid_touch;
    logic [N-1:0]      owner_sel;
    logic [N-1:0]      scan_report;
    logic [N-1:0]      rise;
    logic [N-1:0]      owner_ff, nxt_owner;
    logic [N-1:0]      reported_ff, nxt_reported;
    logic [N-1:0]      out_ff, nxt_out;

    ////////////////////////////////////////////////////////////////////////
    // Start-up tuning and diagnostic sequencer
    tune_diag #(
        .HALF_CYC (BLINK_HALF_CYC),
        .PAIRS    (BLINK_PAIRS)
    ) u_tune (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .tune_done  (tune_done),
        .cap_over   (cap_over),
        .tune_start (tune_start),
        .tif        (tif.src)
    );

    ////////////////////////////////////////////////////////////////////////
    // Strap decode
    function automatic touch_pkg::feature_s decode_strap(input logic [1:0] code);
        touch_pkg::feature_s f;
        f = '0;
        unique case (code)
            `TB_STRAP_GND:  f = '{toggle: 1'b0, suppress: 1'b0};
            `TB_STRAP_R1K5: f = '{toggle: 1'b1, suppress: 1'b0};
            `TB_STRAP_R5K1: f = '{toggle: 1'b0, suppress: 1'b1};
            `TB_STRAP_VDD:  f = '{toggle: 1'b1, suppress: 1'b1};
        endcase
        return f;
    endfunction : decode_strap

    // Lowest index wins among simultaneous touches
    function automatic logic [N-1:0] pick_first(input logic [N-1:0] req);
        logic [N-1:0] g;
        logic         found;
        g     = '0;
        found = 1'b0;
        for (int k = 0; k < N; k++)
        begin
            if (req[k] && !found)
            begin
                g[k]  = 1'b1;
                found = 1'b1;
            end
        end
        return g;
    endfunction : pick_first

    ////////////////////////////////////////////////////////////////////////
    // Strap synchroniser and capture once tuning completes
    assign strap_feat = decode_strap(strap_s2_ff);
    assign capture    = tif.ready && !run_ff;

    always_comb
    begin
        nxt_strap_s1  = feature_strap_pin;
        nxt_strap_s2  = strap_s1_ff;
        nxt_run       = tif.ready;
        nxt_toggle_en = toggle_en_ff;
        nxt_fss_en    = fss_en_ff;
        if (capture)
        begin
            nxt_toggle_en = strap_feat.toggle;
            nxt_fss_en    = strap_feat.suppress;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            strap_s1_ff  <= `TB_STRAP_RST;
            strap_s2_ff  <= `TB_STRAP_RST;
            run_ff       <= 1'b0;
            toggle_en_ff <= 1'b0;
            fss_en_ff    <= 1'b0;
        end
        else
        begin
            strap_s1_ff  <= nxt_strap_s1;
            strap_s2_ff  <= nxt_strap_s2;
            run_ff       <= nxt_run;
            toggle_en_ff <= nxt_toggle_en;
            fss_en_ff    <= nxt_fss_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Suppression ownership, evaluated per scan
    assign sense       = {sense_in_3, sense_in_2, sense_in_1, sense_in_0};
    assign valid_touch = sense & ~tif.bad_mask & {N{run_ff}};
    assign owner_sel   = ((owner_ff & valid_touch) != '0) ? owner_ff
                                                          : pick_first(valid_touch);
    assign scan_report = fss_en_ff ? owner_sel : valid_touch;
    assign rise        = scan_report & ~reported_ff;

    always_comb
    begin
        nxt_owner    = owner_ff;
        nxt_reported = reported_ff;
        if (!run_ff)
        begin
            nxt_owner    = '0;
            nxt_reported = '0;
        end
        else if (scan_valid)
        begin
            nxt_reported = scan_report;
            nxt_owner    = fss_en_ff ? owner_sel : '0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            owner_ff    <= `TB_OUT_RST;
            reported_ff <= `TB_OUT_RST;
        end
        else
        begin
            owner_ff    <= nxt_owner;
            reported_ff <= nxt_reported;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel output decision
    for (genvar i = 0; i < N; i++)
    begin : g_chan
        always_comb
        begin
            nxt_out[i] = out_ff[i];
            if (!run_ff)
            begin
                nxt_out[i] = tif.blink & tif.bad_mask[i];
            end
            else if (scan_valid)
            begin
                if (toggle_en_ff)
                begin
                    nxt_out[i] = out_ff[i] ^ rise[i];
                end
                else
                begin
                    nxt_out[i] = scan_report[i];
                end
            end
        end

        always_ff @(posedge clk_sys)
        begin
            if (reset)
            begin
                out_ff[i] <= 1'b0;
            end
            else
            begin
                out_ff[i] <= nxt_out[i];
            end
        end
    end

    assign button_out_0              = out_ff[0];
    assign button_out_1              = out_ff[1];
    assign button_out_2              = out_ff[2];
    assign button_out_3              = out_ff[3];
    assign tuning_active             = !run_ff;
    assign toggle_mode               = toggle_en_ff;
    assign single_active_suppression = fss_en_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_strap_held_stable:
        assert property (@(posedge clk_sys) disable iff (reset)
            run_ff |=> ($stable(toggle_en_ff) && $stable(fss_en_ff)))
        else $error("strap setting changed without reset");

    a_direct_follow:
        assert property (@(posedge clk_sys) disable iff (reset)
            (run_ff && scan_valid && !toggle_en_ff && !fss_en_ff) |=> (out_ff == $past(valid_touch)))
        else $error("direct output does not follow touch");

    a_toggle_flip:
        assert property (@(posedge clk_sys) disable iff (reset)
            (run_ff && scan_valid && toggle_en_ff) |=> (out_ff == ($past(out_ff) ^ $past(rise))))
        else $error("toggle output did not invert on new touch");

    a_toggle_hold:
        assert property (@(posedge clk_sys) disable iff (reset)
            (run_ff && toggle_en_ff && !scan_valid) |=> $stable(out_ff))
        else $error("toggle output moved between scans");

    a_single_owner:
        assert property (@(posedge clk_sys) disable iff (reset)
            fss_en_ff |-> ($onehot0(reported_ff) && $onehot0(owner_ff)))
        else $error("more than one button reported under suppression");

    a_owner_kept:
        assert property (@(posedge clk_sys) disable iff (reset)
            (run_ff && scan_valid && fss_en_ff && ((owner_ff & valid_touch) != '0)) |=> $stable(owner_ff))
        else $error("owner lost while still touched");

    a_first_kept:
        assert property (@(posedge clk_sys) disable iff (reset)
            (run_ff && scan_valid && fss_en_ff && ((owner_ff & valid_touch) != '0))
            |=> (reported_ff == $past(owner_ff)))
        else $error("first touched sensor not kept as reported");

    a_owner_handover:
        assert property (@(posedge clk_sys) disable iff (reset)
            (run_ff && scan_valid && fss_en_ff && (owner_ff != '0) && ((owner_ff & valid_touch) == '0)
             && (valid_touch != '0))
            |=> (((reported_ff & $past(owner_ff)) == '0) && (reported_ff != '0)))
        else $error("released owner not handed to a touched sensor");

    a_priority_pick:
        assert property (@(posedge clk_sys) disable iff (reset)
            (run_ff && scan_valid && fss_en_ff && ((owner_ff & valid_touch) == '0))
            |=> (owner_ff == ($past(valid_touch) & ~($past(valid_touch) - 4'h1))))
        else $error("wrong sensor picked by priority");

    a_free_multi:
        assert property (@(posedge clk_sys) disable iff (reset)
            (run_ff && scan_valid && !fss_en_ff) |=> (reported_ff == $past(valid_touch)))
        else $error("independent reporting broken");

    a_bad_ignored:
        assert property (@(posedge clk_sys) disable iff (reset)
            run_ff |-> ((reported_ff & tif.bad_mask) == '0))
        else $error("touch reported on over-range sensor");

    a_scan_gated:
        assert property (@(posedge clk_sys) disable iff (reset)
            (run_ff && !scan_valid) |=> ($stable(reported_ff) && $stable(owner_ff)))
        else $error("decision changed without a scan");

    a_reset_clear:
        assert property (@(posedge clk_sys) disable iff (reset)
            $past(reset) |-> (out_ff == '0 && owner_ff == '0 && reported_ff == '0))
        else $error("state not cleared by reset");

endmodule : touch_button_output_logic

// File: core/tune_diag.sv
`timescale 1ns/1ns
`include "touch_consts.svh"

module tune_diag #(
    parameter int unsigned HALF_CYC = `TB_BLINK_HALF_CYC,
    parameter int unsigned PAIRS    = `TB_BLINK_PAIRS
) (
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    // Sensing front end
    input  wire logic                    tune_done,
    input  wire logic [`TB_CHANNELS-1:0] cap_over,
    output logic                         tune_start,
    // Toward the output logic
    tune_if.src                          tif
);

    touch_pkg::tune_state_e  state_ff, nxt_state;
    logic [`TB_CHANNELS-1:0] bad_ff, nxt_bad;
    logic                    blink_ff, nxt_blink;
    logic [31:0]             cnt_ff, nxt_cnt;
    logic [7:0]              flips_ff, nxt_flips;

    ////////////////////////////////////////////////////////////////////////
    // Tuning once per reset, then blink diagnostic for over-range sensors
    always_comb
    begin
        nxt_state = state_ff;
        nxt_bad   = bad_ff;
        nxt_blink = blink_ff;
        nxt_cnt   = cnt_ff;
        nxt_flips = flips_ff;
        unique case (state_ff)
            touch_pkg::ST_REQ:
            begin
                nxt_state = touch_pkg::ST_WAIT;
            end
            touch_pkg::ST_WAIT:
            begin
                if (tune_done)
                begin
                    nxt_bad   = cap_over;
                    nxt_cnt   = 32'h0;
                    nxt_state = (cap_over != `TB_OUT_RST) ? touch_pkg::ST_BLINK : touch_pkg::ST_RUN;
                end
            end
            touch_pkg::ST_BLINK:
            begin
                if (cnt_ff == 32'(HALF_CYC - 1))
                begin
                    nxt_cnt   = 32'h0;
                    nxt_blink = ~blink_ff;
                    nxt_flips = flips_ff + 8'h1;
                    if (flips_ff == 8'(2 * PAIRS - 1))
                    begin
                        nxt_state = touch_pkg::ST_RUN;
                    end
                end
                else
                begin
                    nxt_cnt = cnt_ff + 32'h1;
                end
            end
            touch_pkg::ST_RUN:
            begin
                nxt_state = touch_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_ff <= touch_pkg::ST_REQ;
            bad_ff   <= `TB_OUT_RST;
            blink_ff <= 1'b0;
            cnt_ff   <= 32'h0;
            flips_ff <= 8'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            bad_ff   <= nxt_bad;
            blink_ff <= nxt_blink;
            cnt_ff   <= nxt_cnt;
            flips_ff <= nxt_flips;
        end
    end

    assign tune_start   = (state_ff == touch_pkg::ST_REQ);
    assign tif.ready    = (state_ff == touch_pkg::ST_RUN);
    assign tif.blink    = blink_ff;
    assign tif.bad_mask = bad_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_tune_never_again:
        assert property (@(posedge clk_sys) disable iff (reset) tif.ready |=> (tif.ready && !tune_start))
        else $error("tuning restarted during normal operation");

    a_tune_after_reset:
        assert property (@(posedge clk_sys) $fell(reset) |-> tune_start)
        else $error("no tuning request after reset release");

    a_blink_ends_low:
        assert property (@(posedge clk_sys) disable iff (reset) $rose(tif.ready) |-> !tif.blink)
        else $error("blink still high entering normal operation");

endmodule : tune_diag

// File: verification/sense_front_model.sv
`timescale 1ns/1ns

module sense_front_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // Bench commands
    input  wire logic [3:0] touch,
    input  wire logic       scan_req,
    input  wire logic [3:0] over_cfg,
    input  wire logic [3:0] tune_lat,
    // Toward the block
    input  wire logic       tune_start,
    output logic            tune_done,
    output logic [3:0]      cap_over,
    output logic [3:0]      sense,
    output logic            scan_valid
);
    logic [3:0] cnt_ff;
    logic       busy_ff;

    ////////////////////////////////////////////////////////////////////////
    // Tuning finishes a programmable number of cycles after the request
    always_ff @(posedge clk_sys)
    begin
        if (reset || tune_start)
        begin
            busy_ff <= tune_start;
            cnt_ff  <= tune_lat;
        end
        else if (busy_ff)
        begin
            if (cnt_ff == 4'h0)
                busy_ff <= 1'b0;
            cnt_ff <= cnt_ff - 4'h1;
        end
    end

    assign tune_done  = busy_ff && (cnt_ff == 4'h0);
    // Over-range flags only mean something with tune_done
    assign cap_over   = tune_done ? over_cfg : ~over_cfg;
    // Flags are valid in the scan cycle only, garbage otherwise
    assign sense      = scan_req ? touch : ~touch;
    assign scan_valid = scan_req;

endmodule : sense_front_model

// File: verification/touch_button_output_logic_tb.sv
`timescale 1ns/1ns

module touch_button_output_logic_tb;
    logic       clk_sys  = 1'b0;
    logic       reset    = 1'b1;
    logic [1:0] strap    = 2'h0;
    logic [3:0] touch    = 4'h0;
    logic       scan_req = 1'b0;
    logic [3:0] over_cfg = 4'h0;
    logic [3:0] tune_lat = 4'h0;
    logic       tune_start;
    logic       tune_done;
    logic       scan_valid;
    logic       tuning_active;
    logic       toggle_mode;
    logic       single_active_suppression;
    logic [3:0] cap_over;
    logic [3:0] sense;
    logic [3:0] outs;
    logic [3:0] exp_q[$];
    logic [3:0] st_out;
    logic [3:0] st_rep;
    logic [3:0] bad;
    logic       f_tog;
    logic       f_sup;
    logic       took     = 1'b0;
    int         owner;
    int         m;
    int         n_fail    = 0;
    int         tests_run = 0;
    int         seed      = 10;

    always #10 clk_sys = ~clk_sys;

    touch_button_output_logic #(
        .BLINK_HALF_CYC(4),
        .BLINK_PAIRS   (3)
    ) i_dut (
        .clk_sys                  (clk_sys),
        .reset                    (reset),
        .feature_strap_pin        (strap),
        .sense_in_0               (sense[0]),
        .sense_in_1               (sense[1]),
        .sense_in_2               (sense[2]),
        .sense_in_3               (sense[3]),
        .scan_valid               (scan_valid),
        .tune_done                (tune_done),
        .cap_over                 (cap_over),
        .tune_start               (tune_start),
        .button_out_0             (outs[0]),
        .button_out_1             (outs[1]),
        .button_out_2             (outs[2]),
        .button_out_3             (outs[3]),
        .tuning_active            (tuning_active),
        .toggle_mode              (toggle_mode),
        .single_active_suppression(single_active_suppression)
    );

    sense_front_model i_front (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .touch     (touch),
        .scan_req  (scan_req),
        .over_cfg  (over_cfg),
        .tune_lat  (tune_lat),
        .tune_start(tune_start),
        .tune_done (tune_done),
        .cap_over  (cap_over),
        .sense     (sense),
        .scan_valid(scan_valid)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic results;
        if (n_fail == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    // Reset with a strap code and over-range mask, then watch tuning and blink
    task automatic boot(input logic [1:0] code, input logic [3:0] ovr);
        int         i;
        int         rises = 0;
        int         late  = 0;
        logic       seen  = 1'b0;
        logic [3:0] prev;
        @(posedge clk_sys);
        reset    <= 1'b1;
        strap    <= code;
        over_cfg <= ovr;
        tune_lat <= 4'($unsigned($random(seed)) % 6);
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("reset outputs", outs, 4'h0);
        chk("reset tuning", {3'h0, tuning_active}, 4'h1);
        prev = outs;
        @(posedge clk_sys);
        reset <= 1'b0;
        for (i = 0; i < 300 && (tuning_active || i < 60); i++)
        begin
            @(negedge clk_sys);
            if (tuning_active)
                seen |= tune_start;
            else
                late += tune_start;
            if ((|outs) && !(|prev))
                rises++;
            prev = outs;
        end
        chk("tuning ended", {3'h0, tuning_active}, 4'h0);
        chk("tune request", {3'h0, seen}, 4'h1);
        chk("tune repeated", {3'h0, late != 0}, 4'h0);
        chk("blink count", 4'(rises), (ovr != 4'h0) ? 4'h3 : 4'h0);
        chk("modes", {2'h0, toggle_mode, single_active_suppression}, {2'h0, code[0], code[1]});
        f_tog  = code[0];
        f_sup  = code[1];
        bad    = ovr;
        st_out = 4'h0;
        st_rep = 4'h0;
        owner  = -1;
    endtask : boot

    // One scan: note the expected outputs, then drive it with a gap after
    task automatic scan(input logic [3:0] v, input int gap);
        logic [3:0] eff;
        logic [3:0] rep;
        int         k;
        eff = v & ~bad;
        if (f_sup)
        begin
            if (owner < 0 || !eff[owner])
            begin
                owner = -1;
                for (k = 3; k >= 0; k--)
                    if (eff[k])
                        owner = k;
            end
            rep = (owner < 0) ? 4'h0 : (4'h1 << owner);
        end
        else
            rep = eff;
        st_out = f_tog ? (st_out ^ (rep & ~st_rep)) : rep;
        st_rep = rep;
        exp_q.push_back(st_out);
        @(posedge clk_sys);
        touch    <= v;
        scan_req <= 1'b1;
        if (gap > 0)
        begin
            @(posedge clk_sys);
            scan_req <= 1'b0;
            touch    <= 4'($random(seed));
            repeat (gap - 1) @(posedge clk_sys);
        end
    endtask : scan

    task automatic run_mode(input logic [1:0] code, input logic [3:0] ovr);
        int n;
        boot(code, ovr);
        @(posedge clk_sys);
        strap <= ~code;
        // Staggered touches, owner release, simultaneous touches, retouch
        scan(4'h2, 0);
        scan(4'h6, 0);
        scan(4'h4, 1);
        scan(4'h0, 0);
        scan(4'hf, 2);
        scan(4'he, 0);
        scan(4'h0, 1);
        scan(4'h4, 0);
        scan(4'h0, 0);
        scan(4'h4, 0);
        for (n = 0; n < 40; n++)
            scan(4'($random(seed)), int'($unsigned($random(seed)) % 3));
        @(posedge clk_sys);
        scan_req <= 1'b0;
        repeat (3) @(negedge clk_sys);
        chk("results pending", 4'(exp_q.size()), 4'h0);
        chk("modes held", {2'h0, toggle_mode, single_active_suppression}, {2'h0, code[0], code[1]});
    endtask : run_mode

    ////////////////////////////////////////////////////////////////////////
    // Result watcher: a taken scan shows on the outputs one cycle later
    always @(negedge clk_sys)
    begin
        if (took && exp_q.size() > 0)
            chk("buttons", outs, exp_q.pop_front());
        took = scan_valid && !tuning_active && !reset;
    end

    initial
    begin
        for (m = 0; m < 4; m++)
            run_mode(2'(m), 4'h0);
        run_mode(2'h3, 4'h4);
        run_mode(2'h0, 4'h4);
        results();
    end

    initial
    begin
        #400000;
        n_fail++;
        results();
    end

endmodule : touch_button_output_logic_tb
